// *** hw/rpti_pkg.sv ***
// shared constants and types of the reduced media interface timing and isolate block
// assumes a 100 MHz system clock and 100 Mb/s bit times of one system cycle each
package rpti_pkg;
	// ********************************************************
	// clocking
	// ********************************************************
	localparam int SYS_CLK_MHZ    = 100;                          // system clock rate
	localparam int SYS_PERIOD_NS  = 10;                           // system clock period
	localparam int REF_CLK_MHZ    = 50;                           // reference clock rate
	localparam int REF_PERIOD_NS  = 20;                           // reference clock period
	localparam int REF_DIV        = REF_PERIOD_NS / SYS_PERIOD_NS; // system cycles per reference period
	localparam int BIT_NS         = 10;                           // one bit time at 100 Mb/s
	localparam int BIT_CYC        = BIT_NS / SYS_PERIOD_NS;       // system cycles per bit time
	// ********************************************************
	// latencies in bit times, counts in cycles
	// ********************************************************
	localparam int TX_LAT_BITS    = 17;                           // capture edge to first line bit
	localparam int TX_LAT_CYC     = TX_LAT_BITS * BIT_CYC;
	localparam int CRS_ON_HALF    = 37;                           // 18.5 bit times, in half bits
	localparam int CRS_ON_CYC     = (CRS_ON_HALF * BIT_CYC + 1) / 2; // rounded up
	localparam int CRS_OFF_BITS   = 27;                           // end symbol to carrier drop
	localparam int CRS_OFF_CYC    = CRS_OFF_BITS * BIT_CYC;
	localparam int RX_LAT_BITS    = 38;                           // line symbol to receive data
	localparam int RX_LAT_CYC     = RX_LAT_BITS * BIT_CYC;
	localparam logic [1:0] ELASTIC_DEFAULT = 2'h1;                // elasticity buffer setting
	// ********************************************************
	// loopback and isolate windows
	// ********************************************************
	localparam int LOOP_MAX_US    = 2;                            // transmit enable to receive valid
	localparam int LOOP_MAX_CYC   = LOOP_MAX_US * SYS_CLK_MHZ;    // longest time, rounded down
	localparam int ISO_CLR_MAX_US = 100;                          // isolate bit clear to normal
	localparam int ISO_CLR_CYC    = ISO_CLR_MAX_US * SYS_CLK_MHZ;
	localparam int ISO_RST_MAX_US = 500;                          // reset release to normal
	localparam int ISO_RST_CYC    = ISO_RST_MAX_US * SYS_CLK_MHZ;
	localparam int ISO_CNT_W      = 16;                           // settle counter width
	// ********************************************************
	// data path shape
	// ********************************************************
	localparam int DIBIT_W        = 2;                            // data bits per reference edge
	localparam int RXW_W          = DIBIT_W + 1;                  // buffered word: error flag and dibit
	localparam int FIFO_DEPTH     = 8;                            // receive buffer words
	// isolate sequencer, gray along isolate, settle, normal
	typedef enum logic [1:0] {
		ST_ISOLATE = 2'h0,
		ST_SETTLE  = 2'h1,
		ST_NORMAL  = 2'h3
	} rpti_iso_state_t;
endpackage

// *** hw/rpti_stream_if.sv ***
// valid and ready stream carrier between the block's own modules
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface rpti_stream_if #(parameter int W = 3) ();
	logic         valid; // word offered
	logic         ready; // word accepted when both high
	logic [W-1:0] data;  // word content
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// *** hw/rpti_delay.sv ***
// fixed latency shift line of DEPTH stages
// assumes a synchronous active high reset that clears every stage
`timescale 1ns/100ps
module rpti_delay #(
	parameter int W     = 1,
	parameter int DEPTH = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic [W-1:0] i_data,
	output logic      [W-1:0] o_data
);
	if (DEPTH < 1 || W < 1) begin : g_bad_cfg
		$error("delay line needs at least one stage and one bit");
	end
	// stages, index 0 nearest the input
	logic [W-1:0] stage_ff [DEPTH];
	// ********************************************************
	// shift
	// ********************************************************
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (i_reset)
				stage_ff[i] <= '0;
			else if (i == 0)
				stage_ff[i] <= i_data;
			else
				stage_ff[i] <= stage_ff[i-1];
		end
	end
	assign o_data = stage_ff[DEPTH-1];
endmodule

// *** hw/rpti_fifo.sv ***
// first in first out buffer with valid and ready on both sides
// assumes DEPTH is a power of two; storage has no reset, pointers do
`timescale 1ns/100ps
module rpti_fifo #(
	parameter int W     = 3,
	parameter int DEPTH = 8
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_reset,
	rpti_stream_if.snk                  s_in,
	rpti_stream_if.src                  s_out,
	output logic [$clog2(DEPTH):0]      o_count
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("buffer depth must be a power of two of at least two");
	end
	logic [W-1:0] mem_ff [DEPTH]; // storage words
	logic [AW:0]  wr_ptr_ff;      // write pointer with wrap bit
	logic [AW:0]  rd_ptr_ff;      // read pointer with wrap bit
	wire          push = s_in.valid & s_in.ready;
	wire          pop  = s_out.valid & s_out.ready;
	// honest flags straight from the pointers
	assign o_count     = wr_ptr_ff - rd_ptr_ff;
	assign s_in.ready  = (o_count != (AW+1)'(DEPTH));
	assign s_out.valid = (o_count != '0);
	assign s_out.data  = mem_ff[rd_ptr_ff[AW-1:0]];
	// ********************************************************
	// pointers
	// ********************************************************
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end
	// storage write
	always_ff @(posedge i_clk) begin
		if (push)
			mem_ff[wr_ptr_ff[AW-1:0]] <= s_in.data;
	end
endmodule

// *** hw/rpti_rmii_phy.sv ***
// reduced media interface side of a 10/100 transceiver: transmit capture, receive delivery,
// carrier sense timing, internal loopback and isolate exit sequencing
// assumes the MAC runs on O_REF_CLK, which is made here from I_SYS_CLK, and the line side is
// internal logic on I_SYS_CLK presenting one bit per cycle
`timescale 1ns/100ps
module rpti_rmii_phy
	import rpti_pkg::*;
#(
	parameter int         P_CLR_EXIT_CYC = rpti_pkg::ISO_CLR_CYC,
	parameter int         P_RST_EXIT_CYC = rpti_pkg::ISO_RST_CYC,
	parameter logic [1:0] P_ELASTIC      = rpti_pkg::ELASTIC_DEFAULT,
	parameter int         P_FIFO_DEPTH   = rpti_pkg::FIFO_DEPTH
) (
	input  wire logic                        I_SYS_CLK,
	input  wire logic                        I_RESET,
	output logic                             O_REF_CLK,
	input  wire logic [rpti_pkg::DIBIT_W-1:0] I_TXD,
	input  wire logic                        I_TX_EN,
	output logic                             O_LINE_TX_EN,
	output logic                             O_LINE_TX_BIT,
	input  wire logic                        I_LINE_RX_VALID,
	input  wire logic                        I_LINE_RX_BIT,
	input  wire logic                        I_LINE_RX_ERR,
	input  wire logic                        I_LINE_SSD,
	input  wire logic                        I_LINE_ESD,
	input  wire logic                        I_LOOPBACK,
	input  wire logic                        I_ISOLATE,
	output logic [rpti_pkg::DIBIT_W-1:0]      O_RXD,
	output logic                             O_CRS_DV,
	output logic                             O_RX_DV,
	output logic                             O_RX_ER,
	output logic                             O_RX_OE,
	output logic                             O_ISOLATED
);
	import rpti_pkg::*;
	localparam int ELW        = int'(P_ELASTIC) + 1;          // words held before delivery
	localparam int RX_PRE_CYC = RX_LAT_CYC - 2 * ELW - 1;      // line delay ahead of the buffer
	localparam int CW         = $clog2(P_FIFO_DEPTH) + 1;
	// the clear window counts its isolate cycle as its first, so it needs two at least
	if (P_CLR_EXIT_CYC < 2 || P_CLR_EXIT_CYC >= (1 << ISO_CNT_W) || P_RST_EXIT_CYC < 1
		|| P_RST_EXIT_CYC >= (1 << ISO_CNT_W) || ELW > P_FIFO_DEPTH || RX_PRE_CYC < 1) begin : g_bad_cfg
		$error("settle counts or elasticity setting out of range");
	end
	// ********************************************************
	// reference clock divider
	// ********************************************************
	logic ref_ph_ff;  // phase, high in the cycle ending at a reference rising edge
	logic ref_clk_ff; // reference clock driven to the MAC
	wire  ref_en = ref_ph_ff;
	// one flop toggles, so every reference edge is exactly two system cycles apart
	// the MAC gets a registered clock, free of glitches, and the block keeps a single domain
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ref_ph_ff  <= 1'b0;
			ref_clk_ff <= 1'b0;
		end else begin
			ref_ph_ff  <= ~ref_ph_ff;
			ref_clk_ff <= ref_en;
		end
	end
	assign O_REF_CLK = ref_clk_ff;
	// ********************************************************
	// isolate sequencer
	// ********************************************************
	rpti_iso_state_t       state_ff;    // isolate state
	rpti_iso_state_t       nxt_state;
	logic [ISO_CNT_W-1:0]  settle_ff;   // cycles spent settling
	logic [ISO_CNT_W-1:0]  nxt_settle;
	logic                  from_rst_ff; // settling follows a reset, longer window
	logic                  nxt_from_rst;
	wire  [ISO_CNT_W-1:0]  settle_lim = from_rst_ff ? ISO_CNT_W'(P_RST_EXIT_CYC - 1)
	                                                : ISO_CNT_W'(P_CLR_EXIT_CYC - 1);
	wire                   normal = (state_ff == ST_NORMAL);
	// next state: isolate bit wins at any time, settling ends at the window's last cycle
	always_comb begin
		nxt_state    = state_ff;
		nxt_settle   = settle_ff;
		nxt_from_rst = from_rst_ff;
		case (state_ff)
			ST_ISOLATE: begin
				nxt_settle   = '0;
				nxt_from_rst = 1'b0;
				if (!I_ISOLATE) begin
					// the cycle that saw the bit clear is already part of the window
					nxt_state  = ST_SETTLE;
					nxt_settle = ISO_CNT_W'(1);
				end
			end
			ST_SETTLE: begin
				if (I_ISOLATE) begin
					nxt_state = ST_ISOLATE;
				end else if (settle_ff == settle_lim) begin
					nxt_state = ST_NORMAL;
				end else begin
					nxt_settle = settle_ff + 1'b1;
				end
			end
			ST_NORMAL: begin
				if (I_ISOLATE)
					nxt_state = ST_ISOLATE;
			end
			default: nxt_state = ST_ISOLATE;
		endcase
	end
	// reset leaves the block settling on the long window
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			state_ff    <= ST_SETTLE;
			settle_ff   <= '0;
			from_rst_ff <= 1'b1;
		end else begin
			state_ff    <= nxt_state;
			settle_ff   <= nxt_settle;
			from_rst_ff <= nxt_from_rst;
		end
	end
	assign O_ISOLATED = ~normal;
	// ********************************************************
	// transmit capture and serialiser
	// ********************************************************
	logic [DIBIT_W:0] tx_hold_ff; // captured enable and dibit
	logic             ser_en_d_ff; // serial enable one cycle late, for loopback framing
	wire              ser_en  = tx_hold_ff[DIBIT_W];
	wire              ser_bit = ref_en ? tx_hold_ff[1] : tx_hold_ff[0]; // low bit leaves first
	// the MAC is sampled only at reference edges; isolated, its inputs are not looked at
	// idle dibits are captured too; only the enable bit starts a line burst
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			tx_hold_ff  <= '0;
			ser_en_d_ff <= 1'b0;
		end else begin
			ser_en_d_ff <= ser_en;
			if (ref_en)
				tx_hold_ff <= normal ? {I_TX_EN, I_TXD} : '0;
		end
	end
	// serial stream reaches the line after the transmit latency
	rpti_delay #(.W(2), .DEPTH(TX_LAT_CYC - 1)) u_tx_dly (
		.i_clk   (I_SYS_CLK),
		.i_reset (I_RESET),
		.i_data  ({ser_en & ~I_LOOPBACK, ser_bit & ser_en & ~I_LOOPBACK}),
		.o_data  ({O_LINE_TX_EN, O_LINE_TX_BIT})
	);
	// ********************************************************
	// receive source select
	// ********************************************************
	// loopback takes the serial transmit stream and frames it from its own enable
	// limitation: loopback runs at the line bit rate, not the slow rate, so it lands
	// far inside its bound; the line outputs stay quiet meanwhile
	wire rx_valid = I_LOOPBACK ? ser_en : I_LINE_RX_VALID;
	wire rx_bit   = I_LOOPBACK ? ser_bit : I_LINE_RX_BIT;
	wire rx_err   = I_LOOPBACK ? 1'b0 : I_LINE_RX_ERR;
	wire rx_ssd   = I_LOOPBACK ? (ser_en & ~ser_en_d_ff) : I_LINE_SSD;
	wire rx_esd   = I_LOOPBACK ? (~ser_en & ser_en_d_ff) : I_LINE_ESD;
	wire crs_on;  // delayed start of stream
	wire crs_off; // delayed end of stream
	wire d_valid;
	wire d_bit;
	wire d_err;
	rpti_delay #(.W(1), .DEPTH(CRS_ON_CYC - 1)) u_on_dly (
		.i_clk   (I_SYS_CLK),
		.i_reset (I_RESET),
		.i_data  (rx_ssd),
		.o_data  (crs_on)
	);
	rpti_delay #(.W(1), .DEPTH(CRS_OFF_CYC - 1)) u_off_dly (
		.i_clk   (I_SYS_CLK),
		.i_reset (I_RESET),
		.i_data  (rx_esd),
		.o_data  (crs_off)
	);
	rpti_delay #(.W(3), .DEPTH(RX_PRE_CYC)) u_rx_dly (
		.i_clk   (I_SYS_CLK),
		.i_reset (I_RESET),
		.i_data  ({rx_valid, rx_bit, rx_err}),
		.o_data  ({d_valid, d_bit, d_err})
	);
	// ********************************************************
	// dibit pairing into the elasticity buffer
	// ********************************************************
	rpti_stream_if #(.W(RXW_W)) s_fill ();
	rpti_stream_if #(.W(RXW_W)) s_drain ();
	logic [CW-1:0] fill_cnt;     // words buffered
	logic          half_ff;      // first bit of a pair held
	logic [1:0]    half_ff_bits; // held bit and its error
	logic          ovf_ff;       // a pair was refused by a full buffer
	assign s_fill.valid = d_valid & half_ff;
	assign s_fill.data  = {half_ff_bits[0] | d_err, d_bit, half_ff_bits[1]};
	wire   refused      = s_fill.valid & ~s_fill.ready;
	// pair up line bits; a lone trailing bit is dropped when the stream ends
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			half_ff      <= 1'b0;
			half_ff_bits <= '0;
		end else if (d_valid) begin
			half_ff      <= ~half_ff;
			half_ff_bits <= {d_bit, d_err};
		end else begin
			half_ff      <= 1'b0;
		end
	end
	rpti_fifo #(.W(RXW_W), .DEPTH(P_FIFO_DEPTH)) u_rx_fifo (
		.i_clk   (I_SYS_CLK),
		.i_reset (I_RESET),
		.s_in    (s_fill),
		.s_out   (s_drain),
		.o_count (fill_cnt)
	);
	// ********************************************************
	// delivery at reference edges
	// ********************************************************
	logic              started_ff; // buffer reached its elasticity level this frame
	logic [DIBIT_W-1:0] rxd_ff;    // receive dibit
	logic              rx_dv_ff;   // receive data valid
	logic              rx_er_ff;   // receive error
	wire               level_ok = started_ff | (fill_cnt >= CW'(ELW));
	assign s_drain.ready = ref_en & level_ok; // drain stalls until the buffer holds enough
	wire               deliver  = s_drain.valid & s_drain.ready;
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			started_ff <= 1'b0;
			rxd_ff     <= '0;
			rx_dv_ff   <= 1'b0;
			rx_er_ff   <= 1'b0;
			ovf_ff     <= 1'b0;
		end else begin
			// an overflow in the delivery cycle stays pending for the next word
			ovf_ff <= refused | (ovf_ff & ~deliver);
			if (ref_en) begin
				started_ff <= deliver;
				rxd_ff     <= (deliver && normal) ? s_drain.data[DIBIT_W-1:0] : '0;
				rx_dv_ff   <= deliver & normal;
				rx_er_ff   <= deliver & normal & (s_drain.data[DIBIT_W] | ovf_ff);
			end
		end
	end
	// ********************************************************
	// carrier sense and data valid
	// ********************************************************
	logic carrier_ff; // carrier present on the receive pair
	logic drop_ff;    // end seen, waiting for the next reference edge
	logic crs_dv_ff;  // combined carrier and data valid pin
	wire  drop_now = (crs_off | drop_ff) & ref_en;
	// rising side ignores the reference phase so the control latency stays short
	// falling side waits for a reference edge so the MAC never samples a runt low
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			carrier_ff <= 1'b0;
			drop_ff    <= 1'b0;
			crs_dv_ff  <= 1'b0;
		end else begin
			drop_ff <= (crs_off | drop_ff) & ~ref_en & ~crs_on;
			if (crs_on) begin
				carrier_ff <= normal;
				crs_dv_ff  <= normal;
			end else if (ref_en) begin
				carrier_ff <= carrier_ff & ~drop_now;
				crs_dv_ff  <= normal & ((carrier_ff & ~drop_now)
				              | (~carrier_ff & rx_dv_ff & ~crs_dv_ff));
			end
		end
	end
	// undriven while isolated; enable high only while the pins are driven
	assign O_RX_OE  = normal;
	assign O_RXD    = rxd_ff;
	assign O_RX_DV  = rx_dv_ff;
	assign O_RX_ER  = rx_er_ff;
	assign O_CRS_DV = crs_dv_ff;
	// ********************************************************
	// checks
	// ********************************************************
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);
	// latencies below are in system cycles, one per bit time
	localparam int A_TX  = TX_LAT_CYC;
	localparam int A_ON  = CRS_ON_CYC;
	localparam int A_OFF = CRS_OFF_CYC;
	localparam int A_OFF2 = CRS_OFF_CYC + 1;
	localparam int A_RX  = RX_LAT_CYC;
	localparam int A_RX2 = RX_LAT_CYC + 1;
	logic [ISO_CNT_W:0] a_gap_ff;  // cycles isolate bit low while not normal
	logic [7:0]         a_loop_ff; // cycles since loopback transmit start without receive valid
	logic               a_loop_on_ff;
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET || I_ISOLATE || normal)
			a_gap_ff <= '0;
		else
			a_gap_ff <= a_gap_ff + 1'b1;
		if (I_RESET || rx_dv_ff || !I_LOOPBACK) begin
			a_loop_on_ff <= 1'b0;
			a_loop_ff    <= '0;
		end else if (a_loop_on_ff || (ref_en && I_TX_EN && normal)) begin
			a_loop_on_ff <= 1'b1;
			a_loop_ff    <= a_loop_ff + 1'b1;
		end
	end
	a_ref_period: assert property (ref_en |=> !ref_en ##1 ref_en)
		else $error("reference edge spacing is not two cycles");
	a_tx_latency: assert property (ref_en && I_TX_EN && normal && !I_LOOPBACK |-> ##A_TX O_LINE_TX_EN)
		else $error("line transmit did not start at the set latency");
	a_rx_edge: assert property (($changed(O_RXD) || $changed(O_RX_ER)) |-> $past(ref_en))
		else $error("receive outputs changed away from a reference edge");
	a_crs_on: assert property (rx_ssd && normal && !I_ISOLATE && !rx_esd |-> ##A_ON O_CRS_DV)
		else $error("carrier sense late on start of stream");
	a_crs_off: assert property (rx_esd && !rx_ssd |-> ##[A_OFF:A_OFF2] !O_CRS_DV)
		else $error("carrier sense did not drop after end of stream");
	a_rx_latency: assert property (!I_LOOPBACK && normal && $rose(I_LINE_RX_VALID) && fill_cnt == '0
		&& !started_ff |-> ##[A_RX:A_RX2] O_RX_DV)
		else $error("receive data not delivered at the set latency");
	a_dv_sync: assert property ($rose(O_RX_DV) |-> $past(ref_en))
		else $error("receive valid rose away from a reference edge");
	a_loop_bound: assert property (a_loop_ff <= 8'(LOOP_MAX_CYC))
		else $error("loopback receive valid too late");
	a_clr_exit: assert property (!from_rst_ff |-> a_gap_ff <= (ISO_CNT_W+1)'(P_CLR_EXIT_CYC))
		else $error("isolate exit after clear too slow");
	a_rst_exit: assert property (from_rst_ff |-> a_gap_ff <= (ISO_CNT_W+1)'(P_RST_EXIT_CYC))
		else $error("isolate exit after reset too slow");
	// a dibit taken in the last normal cycle may still sit in the hold register a while
	a_iso_quiet: assert property (!normal |-> !O_RX_OE ##1 (tx_hold_ff == '0 || $past(normal, 2)))
		else $error("isolated block drove or captured");
	c_frame: cover property ($rose(O_RX_DV) ##[1:200] $fell(O_RX_DV));
	c_toggle: cover property (!carrier_ff && O_CRS_DV && O_RX_DV);
	c_loop: cover property (I_LOOPBACK && $rose(O_RX_DV));
	c_exit: cover property ($rose(normal));
	c_drop: cover property ($fell(carrier_ff));
endmodule

// *** verification/rpti_mac_model.sv ***
// mac partner on the reduced interface: sends dibit bursts, collects received dibits
// assumes ref clock high in the system cycle right after each reference edge
`timescale 1ns/100ps
module rpti_mac_model (
	input  wire logic        i_clk,
	input  wire logic        i_ref_clk,
	input  wire logic [1:0]  i_rxd,
	input  wire logic        i_rx_dv,
	input  wire logic [15:0] i_word,
	input  wire logic        i_go,
	output logic      [1:0]  o_txd,
	output logic             o_tx_en
);
	logic [1:0]  rx_q [$];    // dibits taken while receive valid
	logic [15:0] sr;          // burst shift register
	int          left = 0;    // dibits still to send
	initial begin
		o_txd   = 2'h0;
		o_tx_en = 1'b0;
	end
	// ************************************************
	// act just after a reference edge, hold for a full period
	// ************************************************
	always @(negedge i_clk) begin
		if (i_ref_clk === 1'b1) begin
			if (i_rx_dv === 1'b1) rx_q.push_back(i_rxd);
			if (i_go && left == 0) begin
				left = 8;
				sr   = i_word;
			end
			o_tx_en <= (left > 0);
			o_txd   <= (left > 0) ? sr[1:0] : ~o_txd; // idle lines keep moving
			if (left > 0) begin
				sr = sr >> 2;
				left--;
			end
		end
	end
endmodule

// *** verification/testbench.sv ***
// self-checking bench of the reduced interface timing and isolate block
// assumes the mac model beside it; short isolate windows keep the run brief
`timescale 1ns/100ps
module testbench;
	import rpti_pkg::*;
	localparam int CLR_CYC = 20; // isolate clear window
	localparam int RST_CYC = 40; // reset exit window
	logic        I_SYS_CLK = 1'b0, I_RESET = 1'b1, I_LINE_RX_VALID = 1'b0, I_LINE_RX_BIT = 1'b0;
	logic        I_LINE_RX_ERR = 1'b0, I_LINE_SSD = 1'b0, I_LINE_ESD = 1'b0, I_LOOPBACK = 1'b0;
	logic        I_ISOLATE = 1'b0, I_TX_EN, O_REF_CLK, O_LINE_TX_EN, O_LINE_TX_BIT, O_CRS_DV;
	logic        O_RX_DV, O_RX_ER, O_RX_OE, O_ISOLATED, go = 1'b0, line_seen = 1'b0;
	logic [1:0]  I_TXD, O_RXD;         // dibits both ways
	logic [15:0] tx_word = 16'h0000;   // burst for the mac model
	logic        line_q [$];           // serial line bits seen
	logic [31:0] rnd = 32'h0001_1A4C;  // xorshift state
	int          n_mismatch = 0, n_tests = 0, k, c2, c3;
	time         t0;
	rpti_rmii_phy #(.P_CLR_EXIT_CYC(CLR_CYC), .P_RST_EXIT_CYC(RST_CYC)) dut_u (
		.I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .O_REF_CLK(O_REF_CLK), .I_TXD(I_TXD),
		.I_TX_EN(I_TX_EN), .O_LINE_TX_EN(O_LINE_TX_EN), .O_LINE_TX_BIT(O_LINE_TX_BIT),
		.I_LINE_RX_VALID(I_LINE_RX_VALID), .I_LINE_RX_BIT(I_LINE_RX_BIT), .I_LINE_RX_ERR(I_LINE_RX_ERR),
		.I_LINE_SSD(I_LINE_SSD), .I_LINE_ESD(I_LINE_ESD), .I_LOOPBACK(I_LOOPBACK), .I_ISOLATE(I_ISOLATE),
		.O_RXD(O_RXD), .O_CRS_DV(O_CRS_DV), .O_RX_DV(O_RX_DV), .O_RX_ER(O_RX_ER), .O_RX_OE(O_RX_OE),
		.O_ISOLATED(O_ISOLATED));
	rpti_mac_model mac_u (.i_clk(I_SYS_CLK), .i_ref_clk(O_REF_CLK), .i_rxd(O_RXD), .i_rx_dv(O_RX_DV),
		.i_word(tx_word), .i_go(go), .o_txd(I_TXD), .o_tx_en(I_TX_EN));
	// ************************************************
	// clock, line monitor, helpers
	// ************************************************
	always #5 I_SYS_CLK = ~I_SYS_CLK;
	always @(negedge I_SYS_CLK) if (O_LINE_TX_EN === 1'b1) begin
		line_seen = 1'b1;
		line_q.push_back(O_LINE_TX_BIT);
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic pick(input int sel);
		case (sel)
			0: return O_LINE_TX_EN;
			1: return O_CRS_DV;
			2: return O_RX_DV;
			default: return O_ISOLATED;
		endcase
	endfunction
	// falling edges until the chosen output shows a level, bounded
	task automatic wait_lvl(input int sel, input logic lvl, output int c);
		c = 0;
		while (pick(sel) !== lvl && c < 999) begin
			@(negedge I_SYS_CLK);
			c++;
		end
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// nba start so the mac model sees it on a later edge
	task automatic send(input logic [15:0] w);
		tx_word <= w;
		go      <= 1'b1;
		@(posedge I_TX_EN);
		go      <= 1'b0;
	endtask
	task automatic rx_frame(input logic [31:0] w);
		for (int i = 0; i < 33; i++) begin
			I_LINE_RX_VALID = (i < 32);
			I_LINE_RX_BIT   = w[i%32];
			I_LINE_SSD      = (i == 0);
			I_LINE_ESD      = (i == 32);
			@(negedge I_SYS_CLK);
		end
		I_LINE_ESD      = 1'b0;
		I_LINE_RX_VALID = 1'b0;
	endtask
	task automatic finish_test();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// whole sequence needs under 400 cycles; allow fifteen times that
	initial begin
		#60_000;
		n_mismatch++;
		finish_test();
	end
	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		repeat (16) @(negedge I_SYS_CLK);
		check({O_RX_OE, O_ISOLATED}, 2'b01);
		I_RESET = 1'b0;
		wait_lvl(3, 1'b0, k);
		check(k >= RST_CYC && k <= RST_CYC + 3, 1);
		@(posedge O_REF_CLK) t0 = $time;
		@(posedge O_REF_CLK) check(32'($time - t0), REF_PERIOD_NS);
		$display("test reset done");
		@(negedge I_SYS_CLK) rnd = xs(rnd);
		send(rnd[15:0]);
		wait_lvl(0, 1'b1, k);
		check(k, 18);
		repeat (20) @(negedge I_SYS_CLK);
		check(line_q.size(), 16);
		for (int i = 0; i < 16; i++) check(line_q[i], rnd[i]);
		$display("test transmit done");
		rnd = xs(rnd);
		fork
			rx_frame(rnd);
			begin wait_lvl(1, 1'b1, k); check(k, 19); end
			begin wait_lvl(2, 1'b1, c2); check(c2 >= 38 && c2 <= 39, 1); end
			begin repeat (32) @(negedge I_SYS_CLK); wait_lvl(1, 1'b0, c3); check(c3 >= 27 && c3 <= 28, 1); end
		join
		repeat (40) @(negedge I_SYS_CLK);
		check({O_CRS_DV, O_RX_DV, O_RX_ER}, 3'b000);
		check(mac_u.rx_q.size(), 16);
		for (int i = 0; i < 16; i++) check(mac_u.rx_q[i], rnd[2*i+:2]);
		$display("test receive done");
		I_LOOPBACK = 1'b1;
		line_seen  = 1'b0;
		mac_u.rx_q.delete();
		rnd = xs(rnd);
		send(rnd[15:0]);
		wait_lvl(2, 1'b1, k);
		check(k <= 200, 1);
		repeat (60) @(negedge I_SYS_CLK);
		check(line_seen, 1'b0);
		check(mac_u.rx_q.size(), 8);
		for (int i = 0; i < 8; i++) check(mac_u.rx_q[i], rnd[2*i+:2]);
		$display("test loopback done");
		I_LOOPBACK = 1'b0;
		I_ISOLATE  = 1'b1;
		repeat (3) @(negedge I_SYS_CLK);
		check({O_RX_OE, O_ISOLATED}, 2'b01);
		send(16'hFFFF);
		repeat (30) @(negedge I_SYS_CLK);
		check(line_seen, 1'b0);
		I_ISOLATE = 1'b0;
		wait_lvl(3, 1'b0, k);
		check(k >= CLR_CYC && k <= CLR_CYC + 3, 1);
		check(O_RX_OE, 1);
		$display("test isolate done");
		finish_test();
	end
endmodule
